//--- inc/dram_mode_pkg.sv
// Constants for the mode register and row activation block.
package dram_mode_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CMD_W = 25;
  localparam int ROW_W = 15;

  // Command word fields on the sampled command/address bus.
  localparam int CA_BIT0 = 0;
  localparam int CA_BIT1 = 1;
  localparam int CA_BIT2 = 2;
  localparam int CA_BIT3 = 3;
  localparam int CA_ALLBANK = 4;
  localparam int CA_BANK_LO = 7;
  localparam int CA_ROW_LO = 10;
  localparam int CA_MRADDR_LO = 5;
  localparam int CA_MRDATA_LO = 13;

  // Mode register addresses.
  localparam logic [7:0] ADDR_VENDOR_TEST = 8'h09;
  localparam logic [7:0] ADDR_CALIB = 8'h0a;
  localparam logic [7:0] ADDR_TERM = 8'h0b;
  localparam logic [7:0] ADDR_BANK_MASK = 8'h10;
  localparam logic [7:0] ADDR_SEG_MASK = 8'h11;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h3f;

  // Calibration codes and the soft reset pattern.
  localparam logic [7:0] CAL_INIT = 8'hff;
  localparam logic [7:0] CAL_LONG = 8'hab;
  localparam logic [7:0] CAL_SHORT = 8'h56;
  localparam logic [7:0] CAL_RESET = 8'hc3;
  localparam logic [7:0] SOFT_RESET_CODE = 8'hfc;

  typedef enum logic [1:0] {
    CALK_INIT,
    CALK_LONG,
    CALK_SHORT,
    CALK_RESET
  } calib_kind_t;

  // Termination control field positions.
  localparam int TERM_SEL_LO = 0;
  localparam int TERM_PD_BIT = 2;

  // Values after reset.
  localparam logic [1:0] TERM_SEL_RST = 2'h0;
  localparam logic TERM_PD_RST = 1'b0;
  localparam logic [7:0] BANK_MASK_RST = 8'h00;
  localparam logic [7:0] SEG_MASK_RST = 8'h00;

  // Segments that hold memory; mask bits of the other segments are ignored.
  localparam logic [7:0] SEG_LIVE = 8'h3f;

  // Segment field positions in the row address.
  localparam int SEG_LO_SMALL = 11;
  localparam int SEG_LO_LARGE = 12;

  // Synchroniser depth.
  localparam int SYNC_STAGES = 2;

endpackage : dram_mode_pkg

//--- src/dram_mode_act.sv
// Mode register writes, partial refresh masks and row activation decode.
//
// Operation
// [R1] Calibration codes select init, long, short, reset.
// [R2] Undefined calibration codes start nothing.
// [R3] Strapped reference pin ignores every calibration.
// [R4] Two-bit field selects termination strength.
// [R5] Power-down bit keeps or drops termination.
// [R6] Bank mask bit one blocks bank refresh.
// [R7] Segment mask bit one blocks segment refresh.
// [R8] Segment is top three row bits.
// [R9] Masks for segments six, seven ignored.
// [R10] Write-only soft reset register triggers reset.
// [R11] Controller avoids reserved register addresses.
// [R12] Row-open decoded from select and command bits.
// [R13] Controller opens row before column access.
// [R14] Same bank reopen needs precharge, cycle time.
// [R15] Controller honours active and precharge times.
// [R16] Controller spaces activations across banks.
// [R17] At most four activations per window.
// [R18] Window converted to cycles, rounded up.
// [R19] All-bank precharge needs longer wait.
// [R20] Clock enable held minimum pulse width.
// [R21] Controller tracks bank state before activating.
`timescale 1ns/10ps
module dram_mode_act (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic chipSelB,
  input wire logic [24:0] caBus,
  input wire logic calibRefPin,
  input wire logic largeDensity,
  input wire logic powerDown,
  input wire logic refReq,
  input wire logic [2:0] refBank,
  input wire logic [14:0] refRow,
  output logic calibStart,
  output logic [1:0] calibKind,
  output logic [1:0] termSel,
  output logic termPdKeep,
  output logic termActive,
  output logic [7:0] bankMask,
  output logic [7:0] segMask,
  output logic softReset,
  output logic actValid,
  output logic [2:0] actBank,
  output logic [14:0] actRow,
  output logic [7:0] openBanks,
  output logic refreshGo,
  output logic refreshBlocked
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic strapDone;
    logic strapHigh;
    logic calibStart;
    logic [1:0] calibKind;
    logic [1:0] termSel;
    logic termPdKeep;
    logic termActive;
    logic [7:0] bankMask;
    logic [7:0] segMask;
    logic softReset;
    logic actValid;
    logic [2:0] actBank;
    logic [14:0] actRow;
    logic [7:0] openBanks;
    logic refreshGo;
    logic refreshBlocked;
  } state_t;

  state_t state_reg;
  state_t state_next;

  ////////////////////////////////////////////////////////////////////////////
  logic [26:0] syncOut;
  logic csBS;
  logic [24:0] caS;
  logic strapS;

  input_sync #(
    .W(27)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .asyncIn({calibRefPin, chipSelB, caBus}),
    .syncOut(syncOut)
  );

  assign strapS = syncOut[26];
  assign csBS = syncOut[25];
  assign caS = syncOut[24:0];

  ////////////////////////////////////////////////////////////////////////////
  logic cmdAct;
  logic cmdMrw;
  logic cmdPre;
  logic [7:0] mrAddr;
  logic [7:0] mrData;
  logic calCodeOk;
  logic [1:0] calKindDec;
  logic [2:0] refSeg;
  logic refMasked;

  assign cmdAct = !csBS && !caS[dram_mode_pkg::CA_BIT0]
    && caS[dram_mode_pkg::CA_BIT1]; // R12
  assign cmdMrw = !csBS && caS[dram_mode_pkg::CA_BIT0]
    && caS[dram_mode_pkg::CA_BIT1] && caS[dram_mode_pkg::CA_BIT2]
    && !caS[dram_mode_pkg::CA_BIT3];
  assign cmdPre = !csBS && caS[dram_mode_pkg::CA_BIT0]
    && caS[dram_mode_pkg::CA_BIT1] && !caS[dram_mode_pkg::CA_BIT2]
    && caS[dram_mode_pkg::CA_BIT3];
  assign mrAddr = caS[dram_mode_pkg::CA_MRADDR_LO +: 8];
  assign mrData = caS[dram_mode_pkg::CA_MRDATA_LO +: 8];

  always_comb
  begin
    calCodeOk = 1'b1;
    calKindDec = dram_mode_pkg::CALK_INIT;
    case (mrData) // R1
      dram_mode_pkg::CAL_INIT: calKindDec = dram_mode_pkg::CALK_INIT;
      dram_mode_pkg::CAL_LONG: calKindDec = dram_mode_pkg::CALK_LONG;
      dram_mode_pkg::CAL_SHORT: calKindDec = dram_mode_pkg::CALK_SHORT;
      dram_mode_pkg::CAL_RESET: calKindDec = dram_mode_pkg::CALK_RESET;
      default: calCodeOk = 1'b0; // R2
    endcase
  end

  // The segment is the top three live row bits for the chosen density.
  assign refSeg = largeDensity
    ? refRow[dram_mode_pkg::SEG_LO_LARGE +: 3]
    : refRow[dram_mode_pkg::SEG_LO_SMALL +: 3]; // R8
  assign refMasked = state_reg.bankMask[refBank]
    || (state_reg.segMask[refSeg]
    && dram_mode_pkg::SEG_LIVE[refSeg]); // R6 R7 R9

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_next = state_reg;
    state_next.calibStart = 1'b0;
    state_next.softReset = 1'b0;
    state_next.actValid = 1'b0;
    state_next.refreshGo = 1'b0;
    state_next.refreshBlocked = 1'b0;
    // The strap follows its synchronised copy. Latching it only once would
    // catch the cleared synchroniser just after reset and miss the strap.
    state_next.strapDone = 1'b1;
    state_next.strapHigh = strapS;
    if (cmdMrw)
    begin
      case (mrAddr) // R11
        dram_mode_pkg::ADDR_CALIB:
        begin
          if (calCodeOk && !strapS && !state_reg.strapHigh
            && state_reg.strapDone)
          begin
            state_next.calibStart = 1'b1; // R1 R2 R3
            state_next.calibKind = calKindDec;
          end
        end
        dram_mode_pkg::ADDR_TERM:
        begin
          state_next.termSel = mrData[dram_mode_pkg::TERM_SEL_LO +: 2]; // R4
          state_next.termPdKeep = mrData[dram_mode_pkg::TERM_PD_BIT]; // R5
        end
        dram_mode_pkg::ADDR_BANK_MASK: state_next.bankMask = mrData; // R6
        dram_mode_pkg::ADDR_SEG_MASK: state_next.segMask = mrData; // R7
        dram_mode_pkg::ADDR_SOFT_RESET:
        begin
          // Any data, the documented pattern included, resets the die.
          state_next.softReset = 1'b1; // R10
          state_next.termSel = dram_mode_pkg::TERM_SEL_RST;
          state_next.termPdKeep = dram_mode_pkg::TERM_PD_RST;
          state_next.bankMask = dram_mode_pkg::BANK_MASK_RST;
          state_next.segMask = dram_mode_pkg::SEG_MASK_RST;
          state_next.openBanks = 8'h00;
        end
        default: ;
      endcase
    end
    if (cmdAct)
    begin
      state_next.actValid = 1'b1; // R12
      state_next.actBank = caS[dram_mode_pkg::CA_BANK_LO +: 3];
      state_next.actRow = caS[dram_mode_pkg::CA_ROW_LO +: 15];
      state_next.openBanks[caS[dram_mode_pkg::CA_BANK_LO +: 3]] = 1'b1;
    end
    if (cmdPre)
    begin
      if (caS[dram_mode_pkg::CA_ALLBANK])
        state_next.openBanks = 8'h00;
      else
        state_next.openBanks[caS[dram_mode_pkg::CA_BANK_LO +: 3]] = 1'b0;
    end
    if (refReq)
    begin
      state_next.refreshGo = !refMasked; // R6 R7
      state_next.refreshBlocked = refMasked;
    end
    state_next.termActive = (state_next.termSel != 2'h0)
      && (!powerDown || state_next.termPdKeep); // R4 R5
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
      state_reg.termSel <= dram_mode_pkg::TERM_SEL_RST;
      state_reg.termPdKeep <= dram_mode_pkg::TERM_PD_RST;
      state_reg.bankMask <= dram_mode_pkg::BANK_MASK_RST;
      state_reg.segMask <= dram_mode_pkg::SEG_MASK_RST;
    end
    else
      state_reg <= state_next;
  end

  assign calibStart = state_reg.calibStart;
  assign calibKind = state_reg.calibKind;
  assign termSel = state_reg.termSel;
  assign termPdKeep = state_reg.termPdKeep;
  assign termActive = state_reg.termActive;
  assign bankMask = state_reg.bankMask;
  assign segMask = state_reg.segMask;
  assign softReset = state_reg.softReset;
  assign actValid = state_reg.actValid;
  assign actBank = state_reg.actBank;
  assign actRow = state_reg.actRow;
  assign openBanks = state_reg.openBanks;
  assign refreshGo = state_reg.refreshGo;
  assign refreshBlocked = state_reg.refreshBlocked;

  ////////////////////////////////////////////////////////////////////////////
  sequence calBadSeq;
    cmdMrw && mrAddr == dram_mode_pkg::ADDR_CALIB && !calCodeOk;
  endsequence

  sequence actSeq;
    cmdAct ##1 actValid;
  endsequence

  a_calib_code: assert property (@(posedge mclk) disable iff (!rst_b) // R1
    calibStart |-> $past(cmdMrw && mrAddr == dram_mode_pkg::ADDR_CALIB
    && calCodeOk))
    else $error("Calibration started without a defined code.");

  a_calib_ignored: assert property (@(posedge mclk) disable iff (!rst_b) // R2
    calBadSeq |=> !calibStart)
    else $error("Undefined calibration code started calibration.");

  a_strap_blocks: assert property (@(posedge mclk) disable iff (!rst_b) // R3
    state_reg.strapHigh |=> !calibStart)
    else $error("Calibration ran with the reference pin strapped.");

  a_term_level: assert property (@(posedge mclk) disable iff (!rst_b) // R4
    termActive |-> termSel != 2'h0)
    else $error("Termination on while disabled.");

  a_pd_term: assert property (@(posedge mclk) disable iff (!rst_b) // R5
    termActive && $past(powerDown) |-> termPdKeep)
    else $error("Termination kept through power-down without the bit.");

  a_bank_mask: assert property (@(posedge mclk) disable iff (!rst_b) // R6
    refReq && bankMask[refBank] |=> refreshBlocked && !refreshGo)
    else $error("Masked bank was refreshed.");

  a_dead_segs: assert property (@(posedge mclk) disable iff (!rst_b) // R9
    refReq && !bankMask[refBank] && refSeg[2:1] == 2'h3 |=> refreshGo)
    else $error("Mask of an empty segment took effect.");

  a_soft_reset: assert property (@(posedge mclk) disable iff (!rst_b) // R10
    cmdMrw && mrAddr == dram_mode_pkg::ADDR_SOFT_RESET
    |=> softReset && bankMask == 8'h00 && segMask == 8'h00)
    else $error("Soft reset did not restore defaults.");

  a_act_decode: assert property (@(posedge mclk) disable iff (!rst_b) // R12
    actSeq |-> actBank == $past(caS[9:7]) && openBanks[actBank])
    else $error("Row-open captured the wrong bank.");

endmodule : dram_mode_act

//--- src/input_sync.sv
// Two-stage synchroniser for inputs that arrive from the pins.
`timescale 1ns/10ps
module input_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  ////////////////////////////////////////////////////////////////////////////
  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule : input_sync

//--- verification/dram_ctrl_model.sv
// Memory controller model driving the command/address pins.
`timescale 1ns/10ps
module dram_ctrl_model #(
  parameter int RRD = 2,
  parameter int RC = 6,
  parameter int RAS = 4,
  parameter int RP = 2,
  parameter int RPAB = 3,
  parameter int FAW_NS = 300,
  parameter int CK_NS = 40
) (
  input wire logic mclk,
  output logic chipSelB,
  output logic [24:0] caBus
);
  localparam int FAW = (FAW_NS + CK_NS - 1) / CK_NS;
  int cyc = 0;
  int lastAny = -99;
  int tAct [8] = '{default: -99};
  int tPre [8] = '{default: -99};
  int hist [$];
  logic [7:0] isOpen = 8'h00;
  initial chipSelB = 1'b1;
  initial caBus = 25'h0;
  always @(posedge mclk) cyc <= cyc + 1;
  // Column accesses are never issued.
  // The clock enable pin is not driven, so it never toggles.
  task automatic issue(input logic [24:0] w);
    @(posedge mclk);
    chipSelB <= 1'b0;
    caBus <= w;
    @(posedge mclk);
    chipSelB <= 1'b1;
    caBus <= ~w;
  endtask : issue
  // Callers pass defined register addresses only.
  task automatic mode_reg_write_cmd(input logic [7:0] a, input logic [7:0] d);
    issue({4'h0, d, a, 5'h07});
  endtask : mode_reg_write_cmd
  task automatic act(input logic [2:0] b, input logic [14:0] r);
    if (isOpen[b])
      pre(b, 1'b0);
    while (cyc - tAct[b] < RC || cyc - tPre[b] < RP || cyc - lastAny < RRD
        || hist.size() > 3 && cyc - hist[hist.size() - 4] < FAW)
      @(posedge mclk);
    issue({r, b, 7'h02});
    tAct[b] = cyc;
    lastAny = cyc;
    hist.push_back(cyc);
    isOpen[b] = 1'b1;
  endtask : act
  task automatic pre(input logic [2:0] b, input logic all);
    for (int i = 0; i < 8; i++)
      while ((all || i == b) && cyc - tAct[i] < RAS)
        @(posedge mclk);
    issue({15'h0, b, 2'h0, all, 4'hb});
    for (int i = 0; i < 8; i++)
      if (all || i == b)
      begin
        tPre[i] = all ? cyc + RPAB - RP : cyc;
        isOpen[i] = 1'b0;
      end
  endtask : pre
endmodule : dram_ctrl_model

//--- verification/dram_mode_act_test.sv
// Self-checking testbench for the mode register and row activation block.
`timescale 1ns/10ps
module dram_mode_act_test;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic chipSelB;
  logic [24:0] caBus;
  logic calibRefPin = 1'b0;
  logic largeDensity = 1'b0;
  logic powerDown = 1'b0;
  logic refReq = 1'b0;
  logic [2:0] refBank = 3'h0;
  logic [14:0] refRow = 15'h0;
  logic calibStart, termPdKeep, termActive, softReset, actValid;
  logic refreshGo, refreshBlocked;
  logic [1:0] calibKind, termSel;
  logic [7:0] bankMask, segMask, openBanks;
  logic [2:0] actBank;
  logic [14:0] actRow;
  int fails = 0;
  int tests_run = 0;
  int calN = 0;
  int srN = 0;
  int actN = 0;
  integer seed = 32'h82ec9c98;
  logic [7:0] codes [4] = '{8'hff, 8'hab, 8'h56, 8'hc3};

  dram_mode_act dut (.mclk, .rst_b, .chipSelB, .caBus, .calibRefPin,
    .largeDensity, .powerDown, .refReq, .refBank, .refRow, .calibStart,
    .calibKind, .termSel, .termPdKeep, .termActive, .bankMask, .segMask,
    .softReset, .actValid, .actBank, .actRow, .openBanks, .refreshGo,
    .refreshBlocked);
  dram_ctrl_model ctrl (.mclk, .chipSelB, .caBus);

  always #20 mclk = ~mclk;
  // Pulse outputs are counted so that each command shows exactly one.
  always @(posedge mclk)
  begin
    calN <= calN + int'(calibStart);
    srN <= srN + int'(softReset);
    actN <= actN + int'(actValid);
  end

  task automatic check(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : check

  function automatic logic expBlk(logic [7:0] bm, logic [7:0] sm,
    logic [2:0] b, logic [14:0] r, logic lg);
    logic [2:0] s;
    s = lg ? r[14:12] : r[13:11];
    return bm[b] | (sm[s] & (s < 3'h6));
  endfunction : expBlk

  function automatic logic expTerm(logic [1:0] sel, logic keep, logic pd);
    return sel != 2'h0 && (!pd || keep);
  endfunction : expTerm

  task automatic wr(logic [7:0] a, logic [7:0] d);
    ctrl.mode_reg_write_cmd(a, d);
    repeat (5) @(posedge mclk);
    #1;
  endtask : wr

  task automatic doReset(logic s);
    calibRefPin <= s;
    rst_b <= 1'b0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask : doReset

  task wrap_up;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    #800000;
    fails++;
    wrap_up();
  end

  initial
  begin
    logic [7:0] bm, sm, d;
    logic [2:0] b;
    logic [14:0] r;
    logic e;
    int c;
    doReset(1'b0);
    check("bankMask", 8'h00, bankMask);
    check("segMask", 8'h00, segMask);
    check("termSel", 2'h0, termSel);
    check("termPdKeep", 1'b0, termPdKeep);
    foreach (codes[i])
    begin
      c = calN;
      wr(8'h0a, codes[i]);
      check("calibStart", c + 1, calN);
      check("calibKind", i, calibKind);
    end
    for (int i = 0; i < 10; i++)
    begin
      c = calN;
      d = i == 0 ? 8'hfe : 8'($random(seed));
      if (d inside {8'hff, 8'hab, 8'h56, 8'hc3})
        d = 8'h00;
      wr(8'h0a, d);
      check("calibStart", c, calN);
    end
    for (int i = 0; i < 8; i++)
    begin
      powerDown <= 1'($random(seed));
      wr(8'h0b, 8'(i));
      check("termSel", i[1:0], termSel);
      check("termPdKeep", i[2], termPdKeep);
      e = expTerm(i[1:0], i[2], powerDown);
      check("termActive", e, termActive);
    end
    for (int i = 0; i < 12; i++)
    begin
      bm = 8'($random(seed));
      sm = i == 0 ? 8'hc0 : 8'($random(seed));
      wr(8'h10, bm);
      wr(8'h11, sm);
      check("bankMask", bm, bankMask);
      check("segMask", sm, segMask);
      repeat (6)
      begin
        @(posedge mclk);
        refBank <= 3'($random(seed));
        refRow <= 15'($random(seed));
        largeDensity <= 1'($random(seed));
        refReq <= 1'b1;
        @(posedge mclk);
        refReq <= 1'b0;
        #1;
        e = expBlk(bm, sm, refBank, refRow, largeDensity);
        check("refreshBlocked", e, refreshBlocked);
        check("refreshGo", !e, refreshGo);
      end
    end
    for (int i = 0; i < 24; i++)
    begin
      c = actN;
      b = i < 8 ? 3'(i) : 3'($random(seed));
      r = i == 0 ? 15'h7fff : 15'($random(seed));
      ctrl.act(b, r);
      repeat (5) @(posedge mclk);
      #1;
      check("actValid", c + 1, actN);
      check("actBank", b, actBank);
      check("actRow", r, actRow);
      check("openBanks", ctrl.isOpen, openBanks);
    end
    ctrl.pre(3'h0, 1'b1);
    ctrl.act(3'h5, 15'h0);
    c = srN;
    wr(8'h3f, 8'($random(seed)));
    check("softReset", c + 1, srN);
    check("bankMask", 8'h00, bankMask);
    check("segMask", 8'h00, segMask);
    check("termSel", 2'h0, termSel);
    check("openBanks", 8'h00, openBanks);
    doReset(1'b1);
    foreach (codes[i])
    begin
      c = calN;
      wr(8'h0a, codes[i]);
      check("calibStart", c, calN);
    end
    wrap_up();
  end
endmodule : dram_mode_act_test
